// file: ocs_clock_system.sv
`timescale 1ns/10ps
// How it works
// (R1) a four-bit mode field picks one of twelve oscillator modes
// (R2) mode and usb divider choices are latched once after reset
// (R3) usb clock always comes from the primary oscillator path
// (R4) in pll modes with usb enabled the usb clock is 6 or 48 mhz
// (R5) the pll runs only in the four pll modes
// (R6) pll turns a 4 mhz input into a 96 mhz reference
// (R7) eight-setting prescaler divides the input by up to twelve
// (R8) pll postscaler gives the core 1/2, 1/3, 1/4 or 1/6
// (R9) low-speed crystal pll mode feeds the pll without prescaling
// (R10) internal block gives 8 mhz plus a 31 khz to 4 mhz postscaler
// (R11) 8 mhz output is on for selections from 125 khz to 8 mhz
// (R12) slow rc runs when selected or any supervising feature is on
// (R13) the frequency-select field picks direct or postscaled internal clock
// (R14) internal-core modes fix the usb source by mode
// (R15) second pin gives fosc/4 or general i/o in external-usb modes
// (R16) five-bit trim sets frequency, 01111 max, 00000 centre, 10000 min
// (R17) trim change settles within 1 ms with no flag raised
// (R18) low-frequency source bit picks 8 mhz/256 or the slow rc
// (R19) 8 mhz output is on for nonzero select or source bit set
// (R20) full-speed usb takes 96 mhz / 2; bypass feeds primary directly
module ocs_clock_system #(
  parameter int SETTLE_COUNT = ocs_pkg::SETTLE_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [3:0] oscillator_mode_select_i,
  input  wire logic [2:0] usb_prescale_sel_i,
  input  wire logic [1:0] core_postscale_sel_i,
  input  wire logic       usb_full_speed_i,
  input  wire logic       pwrt_en_i,
  input  wire logic       fscm_en_i,
  input  wire logic       wdt_en_i,
  input  wire logic       two_speed_en_i,
  input  wire logic       primary_tick_i,
  input  wire logic       fast_osc_tick_i,
  input  wire logic       slow_rc_tick_i,
  output logic            pll_enable_o,
  output logic            pll_ref_tick_o,
  output logic            usb_clk_tick_o,
  output logic            core_clk_tick_o,
  output logic            fast_osc_enable_o,
  output logic            slow_rc_enable_o,
  output logic      [4:0] frequency_trim_o,
  output logic            second_osc_pin_clkout_o,
  output logic            second_osc_pin_oe_n_o,
  output logic            usb_uses_internal_core_o
);
  logic       rst_s1;
  logic       rst_n;
  logic [2:0] prim_sync;
  logic [2:0] fast_sync;
  logic [2:0] rc_sync;
  logic [9:0] cfg_sync1;
  logic [9:0] cfg_sync2;
  logic       cfg_done;
  logic [3:0] mode;
  logic [2:0] pre_sel;
  logic [1:0] post_sel;
  logic       usb_fs;
  logic [7:0] tuning;
  logic [7:0] control;
  logic [13:0] settle_cnt;
  logic       next_cfg_done;
  logic [3:0] next_mode;
  logic [2:0] next_pre_sel;
  logic [1:0] next_post_sel;
  logic       next_usb_fs;
  logic [7:0] next_tuning;
  logic [7:0] next_control;
  logic [13:0] next_settle_cnt;
  logic [7:0] next_rdata;
  logic       pll_mode;
  logic       int_core;
  logic       pre_in;
  logic       pll_in;
  logic       pll_tick;
  logic       usb_fs_tick;
  logic       usb_ls_tick;
  logic       core_pll_tick;
  logic       fast_post_tick;
  logic       lf_div_tick;
  logic       lf_mid_tick;
  logic       lf_tick;
  logic [2:0] fsel;
  logic [7:0] fast_ratio;
  logic       next_pll_enable;
  logic       next_pll_ref;
  logic       next_usb_tick;
  logic       next_core_tick;
  logic       next_fast_en;
  logic       next_rc_en;
  logic       next_clkout;
  logic       next_oe_n;
  logic       next_usb_int;
  logic       fosc4_tick;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // oscillator ticks come from foreign clocks: two flops then an edge
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prim_sync <= 3'h0;
      fast_sync <= 3'h0;
      rc_sync   <= 3'h0;
    end else begin
      prim_sync <= {prim_sync[1:0], primary_tick_i};
      fast_sync <= {fast_sync[1:0], fast_osc_tick_i};
      rc_sync   <= {rc_sync[1:0], slow_rc_tick_i};
    end
  end

  // no reset: the pair is already full of strap values at release
  always_ff @(posedge core_clk_i) begin
    cfg_sync1 <= {usb_full_speed_i, core_postscale_sel_i,
                  usb_prescale_sel_i, oscillator_mode_select_i};
    cfg_sync2 <= cfg_sync1;
  end

  // configuration is sampled once after reset release and then frozen
  always_comb begin
    next_cfg_done = 1'b1;
    next_mode     = mode;
    next_pre_sel  = pre_sel;
    next_post_sel = post_sel;
    next_usb_fs   = usb_fs;
    if (!cfg_done) begin
      next_mode     = cfg_sync2[3:0];          // see (R1)
      next_pre_sel  = cfg_sync2[6:4];          // see (R2)
      next_post_sel = cfg_sync2[8:7];
      next_usb_fs   = cfg_sync2[9];
    end
  end

  // register bus: tuning and control write, status reads back state
  always_comb begin
    next_tuning     = tuning;
    next_control    = control;
    next_settle_cnt = settle_cnt;
    next_rdata      = 8'h00;
    if (settle_cnt != 14'h0000) begin
      next_settle_cnt = settle_cnt - 14'h0001;
    end
    if (wr_i) begin
      if (addr_i == ocs_pkg::ADDR_TUNING) begin
        next_tuning = wdata_i & ocs_pkg::TUNING_MASK;    // see (R16)
        next_settle_cnt = 14'(SETTLE_COUNT);             // see (R17)
      end else if (addr_i == ocs_pkg::ADDR_CONTROL) begin
        next_control = wdata_i & ocs_pkg::CONTROL_MASK;
      end
    end
    if (rd_i) begin
      if (addr_i == ocs_pkg::ADDR_TUNING) begin
        next_rdata = tuning;
      end else if (addr_i == ocs_pkg::ADDR_CONTROL) begin
        next_rdata = control;
      end else if (addr_i == ocs_pkg::ADDR_STATUS) begin
        next_rdata = {mode, usb_uses_internal_core_o, pll_enable_o,
                      fast_osc_enable_o, slow_rc_enable_o};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done   <= 1'b0;
      mode       <= 4'h0;
      pre_sel    <= 3'h0;
      post_sel   <= 2'h0;
      usb_fs     <= 1'b0;
      tuning     <= ocs_pkg::TUNING_RESET;
      control    <= ocs_pkg::CONTROL_RESET;
      settle_cnt <= 14'h0000;
      rdata_o    <= 8'h00;
    end else begin
      cfg_done   <= next_cfg_done;
      mode       <= next_mode;
      pre_sel    <= next_pre_sel;
      post_sel   <= next_post_sel;
      usb_fs     <= next_usb_fs;
      tuning     <= next_tuning;
      control    <= next_control;
      settle_cnt <= next_settle_cnt;
      rdata_o    <= next_rdata;
    end
  end

  assign pll_mode = (mode == ocs_pkg::MODE_HIGH_SPEED_CRYSTAL_PLL_MODE) ||
                    (mode == ocs_pkg::MODE_LOW_SPEED_CRYSTAL_PLL_MODE) ||
                    (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_PLL_MODE) ||
                    (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_PLL_IO_MODE);    // see (R5)
  assign int_core = (mode >= ocs_pkg::MODE_INTERNAL_CORE_EXT_USB_IO_MODE) &&
                    (mode <= ocs_pkg::MODE_INTERNAL_CORE_HS_USB_MODE);    // see (R14)
  assign pre_in   = prim_sync[1] & ~prim_sync[2];
  assign fsel     = control[ocs_pkg::CTL_FSEL_LSB +: 3];

  // prescaler: primary input down to the 4 mhz pll drive
  ocs_divider u_pre (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (pre_in && pll_mode),
    .ratio_i ({4'h0, ocs_pkg::PRE_DIV[pre_sel]}),       // see (R7)
    .tick_o  (pll_tick)
  );
  // low-speed crystal pll mode bypasses the prescaler
  assign pll_in = (mode == ocs_pkg::MODE_LOW_SPEED_CRYSTAL_PLL_MODE) ?
                  (pre_in && pll_mode) : pll_tick;      // see (R9)

  // pll reference events stand for the 96 mhz output; usb fs takes /2
  ocs_divider u_usb (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (pll_in),                                  // see (R6)
    .ratio_i (8'h02),                                   // see (R20)
    .tick_o  (usb_fs_tick)
  );
  ocs_divider u_usb_ls (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (usb_fs_tick),
    .ratio_i (8'h08),
    .tick_o  (usb_ls_tick)
  );
  ocs_divider u_post (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (pll_in),
    .ratio_i ({4'h0, ocs_pkg::POST_DIV[post_sel]}),     // see (R8)
    .tick_o  (core_pll_tick)
  );

  // internal postscaler: select 7 is 8 mhz direct, lower codes halve
  assign fast_ratio = 8'h01 << (3'h7 - fsel);
  ocs_divider u_fast (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (fast_sync[1] & ~fast_sync[2]),
    .ratio_i (fast_ratio),                              // see (R10)
    .tick_o  (fast_post_tick)
  );
  ocs_divider u_lf (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (fast_sync[1] & ~fast_sync[2]),
    .ratio_i (ocs_pkg::LF_DIV),
    .tick_o  (lf_mid_tick)
  );
  // two stages of sixteen give the divide-by-256 one counter cannot
  ocs_divider u_lf2 (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (lf_mid_tick),
    .ratio_i (ocs_pkg::LF_DIV),
    .tick_o  (lf_div_tick)
  );
  assign lf_tick = tuning[ocs_pkg::TUN_SRC_BIT] ? lf_div_tick :
                   (rc_sync[1] & ~rc_sync[2]);          // see (R18)
  ocs_divider u_fosc4 (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (next_core_tick),
    .ratio_i (8'h04),
    .tick_o  (fosc4_tick)
  );

  always_comb begin
    next_pll_enable = pll_mode;
    next_pll_ref    = pll_in;
    next_usb_tick   = 1'b0;
    if (control[ocs_pkg::CTL_USBEN_BIT]) begin
      next_usb_tick = usb_fs ? usb_fs_tick : usb_ls_tick;  // see (R4)
      if (!pll_mode) begin
        next_usb_tick = pre_in;                        // see (R3) (R20)
      end
    end
    if (int_core) begin
      next_core_tick = (fsel == 3'h0) ? lf_tick : fast_post_tick; // see (R13)
    end else if (pll_mode) begin
      next_core_tick = core_pll_tick;
    end else begin
      next_core_tick = pre_in;
    end
    next_fast_en = (fsel != 3'h0) ||
                   tuning[ocs_pkg::TUN_SRC_BIT];        // see (R11) (R19)
    next_rc_en   = (int_core && fsel == 3'h0 &&
                    !tuning[ocs_pkg::TUN_SRC_BIT]) ||
                   pwrt_en_i || fscm_en_i || wdt_en_i ||
                   two_speed_en_i;                      // see (R12)
    next_usb_int = int_core;
    next_oe_n    = 1'b1;
    next_clkout  = 1'b0;
    if (mode == ocs_pkg::MODE_INTERNAL_CORE_EXT_USB_CLKOUT_MODE || mode == ocs_pkg::MODE_EC ||
        mode == ocs_pkg::MODE_EXTERNAL_CLOCK_PLL_MODE) begin
      next_oe_n   = 1'b0;                               // see (R15)
      next_clkout = fosc4_tick;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_enable_o             <= 1'b0;
      pll_ref_tick_o           <= 1'b0;
      usb_clk_tick_o           <= 1'b0;
      core_clk_tick_o          <= 1'b0;
      fast_osc_enable_o        <= 1'b0;
      slow_rc_enable_o         <= 1'b0;
      frequency_trim_o         <= 5'h00;
      second_osc_pin_clkout_o  <= 1'b0;
      second_osc_pin_oe_n_o    <= 1'b1;
      usb_uses_internal_core_o <= 1'b0;
    end else begin
      pll_enable_o             <= next_pll_enable;
      pll_ref_tick_o           <= next_pll_ref;
      usb_clk_tick_o           <= next_usb_tick;
      core_clk_tick_o          <= next_core_tick;
      fast_osc_enable_o        <= next_fast_en;
      slow_rc_enable_o         <= next_rc_en;
      frequency_trim_o         <= tuning[ocs_pkg::TUN_TRIM_MSB:0]; // see (R16)
      second_osc_pin_clkout_o  <= next_clkout;
      second_osc_pin_oe_n_o    <= next_oe_n;
      usb_uses_internal_core_o <= next_usb_int;
    end
  end
endmodule

// file: ocs_pkg.sv
package ocs_pkg;
  // register map (tuning register has no printed offset, control is coined)
  localparam logic [3:0] ADDR_TUNING  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [7:0] TUNING_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam int TUN_SRC_BIT   = 7;
  localparam int TUN_TRIM_MSB  = 4;
  localparam int CTL_FSEL_LSB  = 4;
  localparam int CTL_USBEN_BIT = 0;
  localparam logic [7:0] TUNING_MASK  = 8'h9F;
  localparam logic [7:0] CONTROL_MASK = 8'h71;
  // oscillator mode encodings of the four-bit configuration field
  localparam logic [3:0] MODE_XT      = 4'h0;
  localparam logic [3:0] MODE_LOW_SPEED_CRYSTAL_PLL_MODE   = 4'h2;
  localparam logic [3:0] MODE_EXTERNAL_CLOCK_IO_MODE    = 4'h4;
  localparam logic [3:0] MODE_EC      = 4'h5;
  localparam logic [3:0] MODE_EXTERNAL_CLOCK_PLL_IO_MODE   = 4'h6;
  localparam logic [3:0] MODE_EXTERNAL_CLOCK_PLL_MODE   = 4'h7;
  localparam logic [3:0] MODE_INTERNAL_CORE_EXT_USB_IO_MODE   = 4'h8;
  localparam logic [3:0] MODE_INTERNAL_CORE_EXT_USB_CLKOUT_MODE  = 4'h9;
  localparam logic [3:0] MODE_INTERNAL_CORE_XT_USB_MODE   = 4'hA;
  localparam logic [3:0] MODE_INTERNAL_CORE_HS_USB_MODE   = 4'hB;
  localparam logic [3:0] MODE_HS      = 4'hC;
  localparam logic [3:0] MODE_HIGH_SPEED_CRYSTAL_PLL_MODE   = 4'hE;
  // prescaler divide ratios for the eight settings
  localparam logic [3:0] PRE_DIV [8] = '{4'h1, 4'h2, 4'h3, 4'h4,
                                         4'h5, 4'h6, 4'hA, 4'hC};
  // postscaler ratios of the pll output for the core
  localparam logic [3:0] POST_DIV [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
  localparam logic [7:0] LF_DIV       = 8'h10;
  localparam int SETTLE_US     = 1000;
  localparam int CLK_MHZ       = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
endpackage

// file: ocs_divider.sv
`timescale 1ns/10ps
module ocs_divider (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] ratio_i,
  output logic            tick_o
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_tick;

  // divides an event stream; ratio 0 or 1 passes every event
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (tick_i) begin
      if (cnt + 8'h01 >= ratio_i) begin
        next_cnt  = 8'h00;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

// file: ocs_osc_source.sv
`timescale 1ns/10ps
module ocs_osc_source #(
  parameter int PRI_HALF  = 310,
  parameter int FAST_HALF = 230,
  parameter int RC_HALF   = 1500
) (
  output logic pri_o,
  output logic fast_o,
  output logic rc_o
);
  // periods stay well above two core cycles so no level is missed
  initial begin
    pri_o  = 1'b0;
    fast_o = 1'b0;
    rc_o   = 1'b0;
  end
  always #PRI_HALF pri_o = ~pri_o;
  always #FAST_HALF fast_o = ~fast_o;
  always #RC_HALF rc_o = ~rc_o;
endmodule

// file: ocs_clock_system_sva.sv
`timescale 1ns/10ps
module ocs_clock_system_sva (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] oscillator_mode_select_i,
  input wire logic       wdt_en_i,
  input wire logic       pll_enable_o,
  input wire logic       pll_ref_tick_o,
  input wire logic       usb_clk_tick_o,
  input wire logic       core_clk_tick_o,
  input wire logic       second_osc_pin_clkout_o,
  input wire logic       fast_osc_enable_o,
  input wire logic       slow_rc_enable_o,
  input wire logic [4:0] frequency_trim_o,
  input wire logic       second_osc_pin_oe_n_o,
  input wire logic       usb_uses_internal_core_o
);
  logic [3:0] cnt;
  logic [3:0] mode_q;
  logic [7:0] tun;
  logic [7:0] ctl;
  logic [2:0] quiet;
  logic       up;
  logic       calm;
  logic       pll_m;
  assign up    = cnt == 4'hF;
  assign calm  = up && quiet == 3'h7;
  assign pll_m = mode_q inside {4'h2, 4'h6, 4'h7, 4'hE};
  // shadows of the registers; strap copy taken well after reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 4'h0;
      mode_q <= 4'h0;
      tun    <= 8'h00;
      ctl    <= 8'h40;
      quiet  <= 3'h0;
    end else begin
      cnt    <= up ? cnt : cnt + 4'h1;
      mode_q <= (cnt == 4'h6) ? oscillator_mode_select_i : mode_q;
      tun    <= (wr_i && addr_i == 4'h0) ? wdata_i : tun;
      ctl    <= (wr_i && addr_i == 4'h1) ? wdata_i : ctl;
      quiet  <= wr_i ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  tune_read_a: assert property (
    rd_i && addr_i == 4'h0 && calm |=> rdata_o == (tun & 8'h9F))
    else $error("tuning read back wrong");
  unmapped_read_a: assert property (rd_i && addr_i > 4'h2 |=> !rdata_o)
    else $error("unmapped read not zero");
  trim_out_a: assert property (
    calm |-> frequency_trim_o == tun[4:0])
    else $error("trim output differs from register");
  fast_en_a: assert property (
    calm |-> fast_osc_enable_o == (ctl[6:4] != 3'h0 || tun[7]))
    else $error("fast oscillator enable wrong");
  pll_mode_a: assert property (up |-> pll_enable_o == pll_m)
    else $error("pll enable wrong for mode");
  pll_idle_a: assert property (up && !pll_m |-> !pll_ref_tick_o)
    else $error("pll input tick in non pll mode");
  usb_off_a: assert property (calm && !ctl[0] |-> !usb_clk_tick_o)
    else $error("usb tick while usb disabled");
  usb_src_a: assert property (
    up |-> usb_uses_internal_core_o == (mode_q[3:2] == 2'b10))
    else $error("internal core flag wrong");
  pin_oe_a: assert property (
    up |-> second_osc_pin_oe_n_o == !(mode_q inside {4'h5, 4'h7, 4'h9}))
    else $error("second pin drive wrong");
  rc_force_a: assert property (
    up && wdt_en_i |-> ##[0:4] slow_rc_enable_o)
    else $error("slow rc not forced on");
  clkout_oe_a: assert property (
    second_osc_pin_clkout_o |-> !second_osc_pin_oe_n_o)
    else $error("clock out pulse while pin released");
  cover property (wr_i && addr_i == 4'h0);
  cover property (second_osc_pin_clkout_o && core_clk_tick_o);
  cover property (pll_enable_o && pll_ref_tick_o);
  cover property (usb_clk_tick_o);
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [3:0] oscillator_mode_select_i = 4'h0;
  logic [2:0] usb_prescale_sel_i = 3'h0;
  logic [1:0] core_postscale_sel_i = 2'h0;
  logic       usb_full_speed_i = 1'b0;
  logic       pwrt_en_i = 1'b0;
  logic       fscm_en_i = 1'b0;
  logic       wdt_en_i = 1'b0;
  logic       two_speed_en_i = 1'b0;
  logic       primary_tick_i;
  logic       fast_osc_tick_i;
  logic       slow_rc_tick_i;
  logic [7:0] rdata_o;
  logic       pll_enable_o, pll_ref_tick_o, usb_clk_tick_o, core_clk_tick_o;
  logic       fast_osc_enable_o, slow_rc_enable_o, second_osc_pin_clkout_o;
  logic       second_osc_pin_oe_n_o, usb_uses_internal_core_o;
  logic [4:0] frequency_trim_o;
  logic [3:0] modes [12] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7,
                             4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE};
  logic [7:0] corner [4] = '{8'h0F, 8'h10, 8'h00, 8'hFF};
  int         mismatches = 0;
  int         n_compared = 0;
  // short settle count keeps the trim shift window small
  ocs_clock_system #(.SETTLE_COUNT(4)) dut (.*);
  ocs_osc_source osc (.pri_o(primary_tick_i), .fast_o(fast_osc_tick_i),
                      .rc_o(slow_rc_tick_i));
  always #50 core_clk_i = ~core_clk_i;
  function automatic logic is_pll(input logic [3:0] m);
    return m inside {4'h2, 4'h6, 4'h7, 4'hE};
  endfunction
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkn(input string w, input int e, input int g, input int t);
    n_compared++;
    if (g > e + t || g < e - t) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    // read data stand for this one cycle; look mid-cycle, away from edges
    @(negedge core_clk_i);
    chk("rdata", e, rdata_o);
    @(posedge core_clk_i);
  endtask
  task automatic boot(input logic [3:0] m, input logic [2:0] p);
    rst_n_i <= 1'b0;
    oscillator_mode_select_i <= m;
    usb_prescale_sel_i <= p;
    core_postscale_sel_i <= 2'($urandom);
    usb_full_speed_i <= 1'($urandom);
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
  endtask
  task automatic count(input int n, output int pe, output int pr,
                       output int us, output int co, output int fe,
                       output int ck);
    logic lp;
    logic lf;
    pe = 0;
    pr = 0;
    us = 0;
    co = 0;
    fe = 0;
    ck = 0;
    lp = primary_tick_i;
    lf = fast_osc_tick_i;
    // pulses are read at the falling edge, clear of the launching edge
    repeat (n) begin
      @(negedge core_clk_i);
      pe += int'(primary_tick_i && !lp);
      fe += int'(fast_osc_tick_i && !lf);
      lp = primary_tick_i;
      lf = fast_osc_tick_i;
      pr += int'(pll_ref_tick_o);
      us += int'(usb_clk_tick_o);
      co += int'(core_clk_tick_o);
      ck += int'(second_osc_pin_clkout_o);
    end
    @(posedge core_clk_i);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [3:0] m;
    logic [7:0] d;
    logic [7:0] c;
    int         pe, pr, us, r;
    int         co, fe, ck, q, k;
    void'($urandom(32'hFD050BEF));
    @(posedge core_clk_i);
    foreach (modes[i]) begin
      m = modes[i];
      boot(m, 3'($urandom));
      chk("pll_en", 8'(is_pll(m)), 8'(pll_enable_o));
      chk("usb_int", 8'(m[3:2] == 2'b10),
          8'(usb_uses_internal_core_o));
      chk("pin_oe", 8'(!(m inside {4'h5, 4'h7, 4'h9})),
          8'(second_osc_pin_oe_n_o));
      rd(4'h2, {m, m[3:2] == 2'b10, is_pll(m), 2'b10});
    end
    oscillator_mode_select_i <= 4'h0;
    repeat (10) @(posedge core_clk_i);
    chk("strap_hold", 8'h01, 8'(pll_enable_o));
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h40);
    for (int i = 0; i < 24; i++) begin
      d = (i < 4) ? corner[i] : 8'($urandom);
      c = {1'b0, 3'(i), 3'($urandom), 1'b0};
      wr(4'h0, d);
      wr(4'h1, c);
      rd(4'h0, d & 8'h9F);
      rd(4'h1, c & 8'h71);
      repeat (8) @(posedge core_clk_i);
      chk("trim", 8'(d[4:0]), 8'(frequency_trim_o));
      chk("fast_en", 8'(c[6:4] != 3'h0 || d[7]),
          8'(fast_osc_enable_o));
    end
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    for (int p = 0; p < 8; p++) begin
      boot(4'hE, 3'(p));
      wr(4'h1, 8'h41);
      count(2000, pe, pr, us, co, fe, ck);
      r = int'(ocs_pkg::PRE_DIV[p]);
      q = int'(ocs_pkg::POST_DIV[core_postscale_sel_i]);
      k = usb_full_speed_i ? 2 : 16;
      chkn("pll_ref", pe, pr * r, r + 2);
      chkn("usb_on", 1, int'(us > 0), 0);
      chkn("usb_rate", pr, us * k, k + 2);
      chkn("core_pll", pr, co * q, q + 2);
    end
    boot(4'h2, 3'h7);
    wr(4'h1, 8'h41);
    count(1200, pe, pr, us, co, fe, ck);
    chkn("low_speed_crystal_pll_mode_ref", pe, pr, 2);
    boot(4'h0, 3'h0);
    wr(4'h1, 8'h41);
    count(1200, pe, pr, us, co, fe, ck);
    chkn("bypass_usb", pe, us, 2);
    chkn("bypass_core", pe, co, 2);
    wr(4'h1, 8'h40);
    count(200, pe, pr, us, co, fe, ck);
    chkn("usb_off", 0, us, 0);
    boot(4'h9, 3'h0);
    for (int f = 1; f < 8; f++) begin
      wr(4'h1, {1'b0, 3'(f), 4'h0});
      count(1000, pe, pr, us, co, fe, ck);
      k = 1 << (7 - f);
      chkn("core_int", fe, co * k, k + 2);
      chkn("clkout", co, ck * 4, 5);
    end
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h00);
    count(3000, pe, pr, us, co, fe, ck);
    chkn("core_lf", fe, co * 256, 258);
    wdt_en_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk("rc_forced", 8'h01, 8'(slow_rc_enable_o));
    wrap_up;
  end
  // tests take about 30000 cycles; the limit allows roughly twice that
  initial begin
    #6000000;
    mismatches++;
    wrap_up;
  end
endmodule
bind ocs_clock_system ocs_clock_system_sva chk (.*);
